// file: core/channel_cal_dsp_config_regs.sv
// Channel trim and processing configuration registers with an APB slave and sample-aligned apply.
module channel_cal_dsp_config_regs (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sample_tick,
  input  wire logic        converter_powered,
  input  wire logic        mod_tick,
  input  wire logic        chan3_bit_in,
  input  wire logic        chan4_bit_in,
  output logic             chan3_bit_out,
  output logic             chan4_bit_out,
  output logic             chan4_mute,
  output logic [8:0]       chan4_volume_half_db,
  output logic [4:0]       chan4_trim_tenth_db,
  output logic             volume_runtime_change_disable,
  output logic             enhanced_dynamics_mode,
  output logic [1:0]       decimation_response_select,
  output logic             average_first_second,
  output logic [1:0]       highpass_select,
  output logic             highpass_programmable
);

  // ****************************************
  // Register storage and applied copies
  // ****************************************
  logic [7:0] chan3_phase_trim;
  logic [7:0] chan4_volume;
  logic [7:0] chan4_gain_trim;
  logic [7:0] chan4_phase_trim;
  logic [7:0] signal_proc_config_zero;
  logic [7:0] chan4_volume_code;
  logic [3:0] chan4_gain_trim_code;
  logic [7:0] chan3_phase_trim_code;
  logic [7:0] chan4_phase_trim_code;
  logic       pend_vol;
  logic       pend_gain;
  logic       pend_ph3;
  logic       pend_ph4;

  // ****************************************
  // Bus decode
  // ****************************************
  logic       setup;
  logic       wr_go;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic       wr_vol;
  logic       wr_gain;
  logic       wr_ph3;
  logic       wr_ph4;
  logic       wr_proc;
  logic       vol_held;
  logic       apply_vol;
  logic       apply_other;
  logic [7:0] status;
  logic [7:0] next_rdata;
  logic       next_err;

  // True when the word index belongs to a mapped register.
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == cal_config_pkg::IDX_CHAN3_PHASE_TRIM) ||
                (i == cal_config_pkg::IDX_CHAN4_VOLUME) ||
                (i == cal_config_pkg::IDX_CHAN4_GAIN_TRIM) ||
                (i == cal_config_pkg::IDX_CHAN4_PHASE_TRIM) ||
                (i == cal_config_pkg::IDX_SIGNAL_PROC_ZERO) ||
                (i == cal_config_pkg::IDX_TRIM_STATUS);
  endfunction : is_mapped

  // Write strobe for one register index on the completing access edge.
  function automatic logic wr_hit(input logic go, input logic [9:0] i, input logic [9:0] target);
    wr_hit = go && (i == target);
  endfunction : wr_hit

  // Pending flag update where a fresh write outranks the apply that clears it.
  function automatic logic pend_next(input logic cur, input logic wr, input logic apply);
    pend_next = wr || (cur && !apply);
  endfunction : pend_next

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign idx    = paddr[11:2];
  assign wbyte  = pwdata[7:0];

  // A write lands only when the low byte lane is enabled, at the access edge.
  assign wr_go   = psel && penable && pready && pwrite && pstrb[0] && (paddr[1:0] == 2'h0);
  assign wr_vol  = wr_hit(wr_go, idx, cal_config_pkg::IDX_CHAN4_VOLUME);
  assign wr_gain = wr_hit(wr_go, idx, cal_config_pkg::IDX_CHAN4_GAIN_TRIM);
  assign wr_ph4  = wr_hit(wr_go, idx, cal_config_pkg::IDX_CHAN4_PHASE_TRIM);
  assign wr_ph3  = wr_hit(wr_go, idx, cal_config_pkg::IDX_CHAN3_PHASE_TRIM);
  assign wr_proc = wr_hit(wr_go, idx, cal_config_pkg::IDX_SIGNAL_PROC_ZERO);

  // ****************************************
  // Software-written registers
  // ****************************************

  // Channel four volume register.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_volume <= cal_config_pkg::RST_VOLUME;
    end
    else if (wr_vol)
    begin
      chan4_volume <= wbyte;
    end
  end

  // Channel four gain trim register; the low nibble is never stored.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_gain_trim <= cal_config_pkg::RST_GAIN_TRIM;
    end
    else if (wr_gain)
    begin
      chan4_gain_trim <= wbyte & cal_config_pkg::GAIN_TRIM_MASK;
    end
  end

  // Channel four phase trim register.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_phase_trim <= cal_config_pkg::RST_PHASE_TRIM;
    end
    else if (wr_ph4)
    begin
      chan4_phase_trim <= wbyte;
    end
  end

  // Channel three phase trim register.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan3_phase_trim <= cal_config_pkg::RST_PHASE_TRIM;
    end
    else if (wr_ph3)
    begin
      chan3_phase_trim <= wbyte;
    end
  end

  // First processing configuration register, applied at once.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      signal_proc_config_zero <= cal_config_pkg::RST_PROC_ZERO;
    end
    else if (wr_proc)
    begin
      signal_proc_config_zero <= wbyte;
    end
  end

  // ****************************************
  // Sample-aligned apply
  // ****************************************

  // Volume changes wait while the hold bit is set and the converter runs.
  assign vol_held    = signal_proc_config_zero[cal_config_pkg::PROC_VOL_HOLD] && converter_powered;
  assign apply_vol   = sample_tick && !vol_held;
  assign apply_other = sample_tick;

  // Pending flags mark register values not yet copied to the datapath.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_vol  <= 1'b0;
      pend_gain <= 1'b0;
      pend_ph3  <= 1'b0;
      pend_ph4  <= 1'b0;
    end
    else
    begin
      pend_vol  <= pend_next(pend_vol, wr_vol, apply_vol);
      pend_gain <= pend_next(pend_gain, wr_gain, apply_other);
      pend_ph3  <= pend_next(pend_ph3, wr_ph3, apply_other);
      pend_ph4  <= pend_next(pend_ph4, wr_ph4, apply_other);
    end
  end

  // Applied volume code, copied only on an allowed sample boundary.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_volume_code <= cal_config_pkg::RST_VOLUME;
    end
    else if (apply_vol && pend_vol)
    begin
      chan4_volume_code <= chan4_volume;
    end
  end

  // Applied gain trim code.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_gain_trim_code <= cal_config_pkg::RST_GAIN_TRIM[7:4];
    end
    else if (apply_other && pend_gain)
    begin
      chan4_gain_trim_code <= chan4_gain_trim[7:4];
    end
  end

  // Applied phase trim codes for both channels.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan3_phase_trim_code <= cal_config_pkg::RST_PHASE_TRIM;
      chan4_phase_trim_code <= cal_config_pkg::RST_PHASE_TRIM;
    end
    else
    begin
      if (apply_other && pend_ph3)
      begin
        chan3_phase_trim_code <= chan3_phase_trim;
      end
      if (apply_other && pend_ph4)
      begin
        chan4_phase_trim_code <= chan4_phase_trim;
      end
    end
  end

  // ****************************************
  // Decoded datapath settings
  // ****************************************

  // Volume in signed half-dB steps relative to unity, and the mute flag.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan4_mute           <= 1'b0;
      chan4_volume_half_db <= 9'h000;
      chan4_trim_tenth_db  <= 5'h00;
    end
    else
    begin
      chan4_mute           <= (chan4_volume_code == cal_config_pkg::VOLUME_MUTE_CODE);
      chan4_volume_half_db <= {1'b0, chan4_volume_code} - cal_config_pkg::VOLUME_UNITY;
      chan4_trim_tenth_db  <= {1'b0, chan4_gain_trim_code} - cal_config_pkg::GAIN_TRIM_ZERO;
    end
  end

  // Processing field outputs taken straight from the register.
  assign volume_runtime_change_disable = signal_proc_config_zero[cal_config_pkg::PROC_VOL_HOLD];
  assign enhanced_dynamics_mode = signal_proc_config_zero[cal_config_pkg::PROC_ENHANCED];
  assign decimation_response_select =
    signal_proc_config_zero[cal_config_pkg::PROC_DECIM_LSB +: 2];
  assign highpass_select = signal_proc_config_zero[cal_config_pkg::PROC_HPF_LSB +: 2];

  // Averaging runs only on its single legal code; reserved codes leave it off.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      average_first_second  <= 1'b0;
      highpass_programmable <= 1'b0;
    end
    else
    begin
      average_first_second <=
        signal_proc_config_zero[cal_config_pkg::PROC_AVG_LSB +: 2] == cal_config_pkg::AVG_FIRST_SECOND;
      highpass_programmable <=
        signal_proc_config_zero[cal_config_pkg::PROC_HPF_LSB +: 2] == cal_config_pkg::HPF_PROGRAMMABLE;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Status shows pending apply, volume hold and reserved codes in use.
  always_comb
  begin
    status = 8'h00;
    status[cal_config_pkg::STAT_VOL_PEND]  = pend_vol;
    status[cal_config_pkg::STAT_GAIN_PEND] = pend_gain;
    status[cal_config_pkg::STAT_PH3_PEND]  = pend_ph3;
    status[cal_config_pkg::STAT_PH4_PEND]  = pend_ph4;
    status[cal_config_pkg::STAT_VOL_HELD]  = vol_held;
    status[cal_config_pkg::STAT_DECIM_RSVD] =
      decimation_response_select == cal_config_pkg::DECIM_RESERVED;
    status[cal_config_pkg::STAT_AVG_RSVD] =
      signal_proc_config_zero[cal_config_pkg::PROC_AVG_LSB + 1];
  end

  // Read data selection by word index.
  always_comb
  begin
    next_rdata = 8'h00;
    case (idx)
      cal_config_pkg::IDX_CHAN3_PHASE_TRIM: next_rdata = chan3_phase_trim;
      cal_config_pkg::IDX_CHAN4_VOLUME:     next_rdata = chan4_volume;
      cal_config_pkg::IDX_CHAN4_GAIN_TRIM:  next_rdata = chan4_gain_trim & cal_config_pkg::GAIN_TRIM_MASK;
      cal_config_pkg::IDX_CHAN4_PHASE_TRIM: next_rdata = chan4_phase_trim;
      cal_config_pkg::IDX_SIGNAL_PROC_ZERO: next_rdata = signal_proc_config_zero;
      cal_config_pkg::IDX_TRIM_STATUS:      next_rdata = status;
      default:                              next_rdata = 8'h00;
    endcase
  end

  // Unmapped, misaligned or status writes answer with an error.
  assign next_err = !is_mapped(idx) || (paddr[1:0] != 2'h0) ||
                    (pwrite && idx == cal_config_pkg::IDX_TRIM_STATUS);

  // Answer is captured in the setup cycle and stands through the access phase.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      pslverr <= next_err;
    end
    else if (!psel)
    begin
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Phase delay lines
  // ****************************************

  // Channel three delay in modulator periods.
  phase_delay_line #(
    .DEPTH (cal_config_pkg::PHASE_DEPTH)
  ) u_chan3_delay (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .mod_tick   (mod_tick),
    .bit_in     (chan3_bit_in),
    .delay_code (chan3_phase_trim_code),
    .bit_out    (chan3_bit_out)
  );

  // Channel four delay in modulator periods.
  phase_delay_line #(
    .DEPTH (cal_config_pkg::PHASE_DEPTH)
  ) u_chan4_delay (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .mod_tick   (mod_tick),
    .bit_in     (chan4_bit_in),
    .delay_code (chan4_phase_trim_code),
    .bit_out    (chan4_bit_out)
  );

endmodule : channel_cal_dsp_config_regs

// file: shared/cal_config_pkg.sv
// Register map, field layout and reset values of the channel trim and processing configuration bank.
package cal_config_pkg;

  // ****************************************
  // Register indices, byte address is index times four
  // ****************************************
  localparam logic [9:0] IDX_CHAN3_PHASE_TRIM  = 10'h04a;
  localparam logic [9:0] IDX_CHAN4_VOLUME      = 10'h04d;
  localparam logic [9:0] IDX_CHAN4_GAIN_TRIM   = 10'h04e;
  localparam logic [9:0] IDX_CHAN4_PHASE_TRIM  = 10'h04f;
  localparam logic [9:0] IDX_SIGNAL_PROC_ZERO  = 10'h06b;
  localparam logic [9:0] IDX_TRIM_STATUS       = 10'h070;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_VOLUME      = 8'hc9;
  localparam logic [7:0] RST_GAIN_TRIM   = 8'h80;
  localparam logic [7:0] RST_PHASE_TRIM  = 8'h00;
  localparam logic [7:0] RST_PROC_ZERO   = 8'h01;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int         GAIN_TRIM_LSB    = 4;
  localparam logic [7:0] GAIN_TRIM_MASK   = 8'hf0;
  localparam int         PROC_VOL_HOLD    = 7;
  localparam int         PROC_ENHANCED    = 6;
  localparam int         PROC_DECIM_LSB   = 4;
  localparam int         PROC_AVG_LSB     = 2;
  localparam int         PROC_HPF_LSB     = 0;
  localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
  localparam logic [8:0] VOLUME_UNITY     = 9'h0c9;
  localparam logic [4:0] GAIN_TRIM_ZERO   = 5'h08;
  localparam logic [1:0] AVG_FIRST_SECOND = 2'h1;
  localparam logic [1:0] DECIM_RESERVED   = 2'h3;
  localparam logic [1:0] HPF_PROGRAMMABLE = 2'h0;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int STAT_VOL_PEND   = 0;
  localparam int STAT_GAIN_PEND  = 1;
  localparam int STAT_PH3_PEND   = 2;
  localparam int STAT_PH4_PEND   = 3;
  localparam int STAT_VOL_HELD   = 4;
  localparam int STAT_DECIM_RSVD = 5;
  localparam int STAT_AVG_RSVD   = 6;

  // ****************************************
  // Phase delay line length in modulator cycles
  // ****************************************
  localparam int PHASE_DEPTH = 255;

endpackage : cal_config_pkg

// file: core/phase_delay_line.sv
// Bit-stream delay line with a programmable delay counted in modulator clock periods.
module phase_delay_line #(
  parameter int DEPTH = cal_config_pkg::PHASE_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       mod_tick,
  input  wire logic       bit_in,
  input  wire logic [7:0] delay_code,
  output logic            bit_out
);

  // ****************************************
  // Storage
  // ****************************************
  logic [DEPTH-1:0] line;
  logic             tap;

  // Shifts one position per modulator period.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line <= '0;
    end
    else if (mod_tick)
    begin
      line <= {line[DEPTH-2:0], bit_in};
    end
  end

  // Code zero passes the bit straight, code n takes the bit n periods old.
  always_comb
  begin
    if (delay_code == 8'h00)
    begin
      tap = bit_in;
    end
    else
    begin
      tap = line[delay_code - 8'h01];
    end
  end

  // Registers the selected bit on each modulator period.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_out <= 1'b0;
    end
    else if (mod_tick)
    begin
      bit_out <= tap;
    end
  end

endmodule : phase_delay_line

// file: testbench/channel_cal_dsp_config_regs_monitor.sv
// Concurrent checks on the ports of the trim and processing configuration bank.
module channel_cal_dsp_config_regs_monitor (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sample_tick,
  input wire logic        converter_powered,
  input wire logic        chan4_mute,
  input wire logic [8:0]  chan4_volume_half_db,
  input wire logic [4:0]  chan4_trim_tenth_db,
  input wire logic        volume_runtime_change_disable,
  input wire logic        enhanced_dynamics_mode,
  input wire logic [1:0]  decimation_response_select,
  input wire logic        average_first_second,
  input wire logic [1:0]  highpass_select,
  input wire logic        highpass_programmable
);
  // ****************************************
  // Decode and write data history
  // ****************************************
  logic [9:0]  idx;
  logic        mapped;
  logic        proc_wr;
  logic [31:0] wd1;
  logic [31:0] wd2;

  // Word index, legal places, and a completed write to the processing register.
  assign idx     = paddr[11:2];
  assign mapped  = (paddr[1:0] == 2'h0) && (idx == cal_config_pkg::IDX_CHAN3_PHASE_TRIM ||
                   idx == cal_config_pkg::IDX_CHAN4_VOLUME || idx == cal_config_pkg::IDX_CHAN4_GAIN_TRIM ||
                   idx == cal_config_pkg::IDX_CHAN4_PHASE_TRIM || idx == cal_config_pkg::IDX_SIGNAL_PROC_ZERO ||
                   idx == cal_config_pkg::IDX_TRIM_STATUS);
  assign proc_wr = psel && penable && pwrite && pstrb[0] && mapped && idx == cal_config_pkg::IDX_SIGNAL_PROC_ZERO;

  // Keeps the write data of the last two cycles so field checks can look back.
  always_ff @(posedge ref_clk)
  begin
    wd1 <= pwdata;
    wd2 <= wd1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************
  // Assertions
  // ****************************************
  chk_decode_error: assert property (psel && penable |->
    pslverr == (!mapped || (pwrite && idx == cal_config_pkg::IDX_TRIM_STATUS)))
    else $error("bus error flag does not match the address decode");
  chk_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above the low byte is not zero");
  chk_gain_low_zero: assert property (psel && penable && !pwrite && mapped &&
    idx == cal_config_pkg::IDX_CHAN4_GAIN_TRIM |-> prdata[3:0] == 4'h0)
    else $error("gain trim low nibble reads non-zero");
  chk_proc_fields: assert property (proc_wr |=> {volume_runtime_change_disable, enhanced_dynamics_mode,
    decimation_response_select, highpass_select} == {wd1[7:4], wd1[1:0]})
    else $error("processing fields do not follow the written byte");
  chk_average_code: assert property (proc_wr |=> ##1 average_first_second == (wd2[3:2] == 2'h1))
    else $error("averaging flag does not follow its field");
  chk_hpf_decode: assert property (highpass_programmable == ($past(highpass_select) == 2'h0))
    else $error("programmable high-pass flag does not follow its field");
  chk_apply_aligned: assert property ($changed(chan4_trim_tenth_db) || $changed(chan4_volume_half_db) ||
    $changed(chan4_mute) |-> $past(sample_tick, 2))
    else $error("applied trim changed away from a sample boundary");
  chk_volume_held: assert property (sample_tick && volume_runtime_change_disable && converter_powered
    |=> ##1 $stable(chan4_volume_half_db) && $stable(chan4_mute))
    else $error("volume changed while changes are held");
  chk_trim_range: assert property (!(chan4_trim_tenth_db inside {[5'h08:5'h17]}))
    else $error("gain trim step outside minus eight to plus seven");
  chk_volume_range: assert property (!chan4_mute |->
    chan4_volume_half_db inside {[9'h138:9'h1ff], [9'h000:9'h036]})
    else $error("volume step outside minus 200 to plus 54");
endmodule : channel_cal_dsp_config_regs_monitor

bind channel_cal_dsp_config_regs channel_cal_dsp_config_regs_monitor i_channel_cal_dsp_config_regs_monitor (
  .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .sample_tick,
  .converter_powered, .chan4_mute, .chan4_volume_half_db, .chan4_trim_tenth_db, .volume_runtime_change_disable,
  .enhanced_dynamics_mode, .decimation_response_select, .average_first_second, .highpass_select,
  .highpass_programmable
);

// file: testbench/test_channel_cal_dsp_config_regs.sv
// Self-checking bench for the trim and processing configuration bank.
module test_channel_cal_dsp_config_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Addresses, stimulus and observed signals
  // ****************************************
  localparam logic [11:0] A_PH3  = {cal_config_pkg::IDX_CHAN3_PHASE_TRIM, 2'b00};
  localparam logic [11:0] A_VOL  = {cal_config_pkg::IDX_CHAN4_VOLUME, 2'b00};
  localparam logic [11:0] A_GAIN = {cal_config_pkg::IDX_CHAN4_GAIN_TRIM, 2'b00};
  localparam logic [11:0] A_PH4  = {cal_config_pkg::IDX_CHAN4_PHASE_TRIM, 2'b00};
  localparam logic [11:0] A_PROC = {cal_config_pkg::IDX_SIGNAL_PROC_ZERO, 2'b00};
  localparam logic [11:0] A_STAT = {cal_config_pkg::IDX_TRIM_STATUS, 2'b00};

  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h1;
  logic        sample_tick = 1'b0;
  logic        converter_powered = 1'b1;
  logic        mod_tick = 1'b0;
  logic        chan3_bit_in = 1'b0;
  logic        chan4_bit_in = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chan3_bit_out;
  logic        chan4_bit_out;
  logic        chan4_mute;
  logic [8:0]  chan4_volume_half_db;
  logic [4:0]  chan4_trim_tenth_db;
  logic        volume_runtime_change_disable;
  logic        enhanced_dynamics_mode;
  logic [1:0]  decimation_response_select;
  logic        average_first_second;
  logic [1:0]  highpass_select;
  logic        highpass_programmable;
  logic [3:0]  strb = 4'h1;
  logic [31:0] r;
  logic        e;
  logic [8:0]  prev;
  int          checks = 0;
  int          miscompares = 0;
  logic [7:0]  vc [5] = '{8'h01, 8'hc9, 8'hca, 8'hff, 8'h00};
  logic [8:0]  vh [5] = '{9'h138, 9'h000, 9'h001, 9'h036, 9'h000};
  logic [3:0]  gc [3] = '{4'h0, 4'h8, 4'hf};
  logic [4:0]  gh [3] = '{5'h18, 5'h00, 5'h07};

  channel_cal_dsp_config_regs i_channel_cal_dsp_config_regs (
    .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .sample_tick, .converter_powered, .mod_tick, .chan3_bit_in, .chan4_bit_in, .chan3_bit_out, .chan4_bit_out,
    .chan4_mute, .chan4_volume_half_db, .chan4_trim_tenth_db, .volume_runtime_change_disable,
    .enhanced_dynamics_mode, .decimation_response_select, .average_first_second, .highpass_select,
    .highpass_programmable
  );

  // Free-running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  // ****************************************
  // Tasks
  // ****************************************
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Compares one observed value with its expectation.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // One bus transfer: setup, then access held until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= strb;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        miscompares++;
        close_out();
      end
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes one register.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr

  // Reads one register and checks data and error flag.
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 8'h00, r, e);
    cmp(r, x);
    cmp(32'(e), 32'(xe));
  endtask : rd

  // Pulses a sample boundary and waits for the decoded outputs.
  task automatic tick();
    @(posedge ref_clk);
    sample_tick <= 1'b1;
    @(posedge ref_clk);
    sample_tick <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    cmp(32'({chan4_volume_half_db, chan4_trim_tenth_db, highpass_select}), 32'h1);
    rd(A_PH3, 32'h00, 1'b0);
    rd(A_VOL, 32'hc9, 1'b0);
    rd(A_GAIN, 32'h80, 1'b0);
    rd(A_PH4, 32'h00, 1'b0);
    rd(A_PROC, 32'h01, 1'b0);
    strb = 4'h0;
    wr(A_VOL, 8'h55);
    strb = 4'h1;
    rd(A_VOL, 32'hc9, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    rd(A_VOL + 12'h1, 32'hc9, 1'b1);
    apb(1'b1, A_STAT, 8'hff, r, e);
    cmp(32'(e), 32'h1);
    prev = 9'h000;
    for (int i = 0; i < 5; i++)
    begin
      wr(A_VOL, vc[i]);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp(32'(chan4_volume_half_db), 32'(prev));
      rd(A_STAT, 32'h1, 1'b0);
      tick();
      cmp(32'(chan4_mute), 32'(vc[i] == 8'h00));
      if (vc[i] != 8'h00)
        cmp(32'(chan4_volume_half_db), 32'(vh[i]));
      prev = vh[i];
    end
    wr(A_GAIN, 8'hf0);
    rd(A_GAIN, 32'hf0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(A_GAIN, {gc[i], 4'h0});
      tick();
      cmp(32'(chan4_trim_tenth_db), 32'(gh[i]));
    end
    wr(A_PROC, 8'h81);
    wr(A_VOL, 8'h10);
    tick();
    cmp(32'(chan4_mute), 32'h1);
    @(posedge ref_clk);
    converter_powered <= 1'b0;
    tick();
    cmp(32'({chan4_mute, chan4_volume_half_db}), 32'h147);
    @(posedge ref_clk);
    converter_powered <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(A_PROC, 8'(i * 8'h55));
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp(32'({volume_runtime_change_disable, enhanced_dynamics_mode, decimation_response_select,
               average_first_second, highpass_select, highpass_programmable}),
          32'({2'(i), 2'(i), i == 1, 2'(i), i == 0}));
      rd(A_PROC, 32'(i * 8'h55), 1'b0);
    end
    wr(A_PH3, 8'h03);
    wr(A_PH4, 8'hff);
    rd(A_PH3, 32'h03, 1'b0);
    rd(A_PH4, 32'hff, 1'b0);
    tick();
    for (int j = 0; j < 257; j++)
    begin
      @(posedge ref_clk);
      mod_tick     <= 1'b1;
      chan3_bit_in <= (j == 0);
      chan4_bit_in <= (j == 0);
      @(posedge ref_clk);
      mod_tick <= 1'b0;
      @(negedge ref_clk);
      cmp(32'(chan3_bit_out), 32'(j == 3));
      cmp(32'(chan4_bit_out), 32'(j == 255));
    end
    close_out();
  end
endmodule : test_channel_cal_dsp_config_regs
